// >>> common/ocd_pkg.sv
// Package for the option configuration decoder: option encodings and field positions.
// Assumes a single system clock domain and an option store read once after reset.
package ocd_pkg;

   // Option word layout, as presented by the option store.
   localparam int OPT_W            = 10;
   localparam int OPT_SECURE_BIT   = 0;
   localparam int OPT_FASTWAKE_BIT = 1;
   localparam int OPT_IRQ0_BIT     = 2;
   localparam int OPT_IRQ1_BIT     = 3;
   localparam int OPT_CMPEDGE_LSB  = 4;
   localparam int OPT_CMPEDGE_MSB  = 5;
   localparam int OPT_PWMGATE_BIT  = 6;
   localparam int OPT_TMCLK_BIT    = 7;
   localparam int OPT_PWMRES_BIT   = 8;
   localparam int OPT_SPARE_BIT    = 9;

   // Option word reset value, held until the store has been sampled.
   localparam logic [OPT_W-1:0] OPT_RESET = 10'h000;

   // Register field positions.
   localparam int TMCTL_SRC_LSB    = 4;
   localparam int TMCTL_SRC_MSB    = 7;
   localparam logic [3:0] TMCTL_SRC_FAST = 4'h2;
   localparam int TMSCALE_PWM_BIT  = 7;
   localparam int XTAL_EN_BIT      = 7;
   localparam int XTAL_RANGE_LSB   = 5;
   localparam int XTAL_RANGE_MSB   = 6;
   localparam int CLOCK_MODE_REG_RST_BIT    = 0;
   localparam int PIN_A_BIT5       = 5;

   // Wake-up delay counts in system clocks; plain defaults.
   localparam logic [7:0] WAKE_SLOW_CNT = 8'hff;
   localparam logic [7:0] WAKE_FAST_CNT = 8'h2d;

   // Reset value of the timer bit-8 history.
   localparam logic       T16_BIT8_RESET = 1'b0;

   typedef enum logic [1:0] {
      OCD_EDGE_BOTH,
      OCD_EDGE_RISE,
      OCD_EDGE_FALL,
      OCD_EDGE_RSVD
   } ocd_edge_t;

   typedef enum logic [1:0] {
      OCD_XTAL_OFF,
      OCD_XTAL_LOW,
      OCD_XTAL_MID,
      OCD_XTAL_HIGH
   } ocd_xtal_t;

   typedef enum logic [1:0] {
      OCD_LD_IDLE,
      OCD_LD_REQ,
      OCD_LD_DONE
   } ocd_ld_state_t;

endpackage

// >>> rtl/ocd_edge_detect.sv
// Edge detector with selectable edge: both, rising only or falling only.
// Assumes the sampled input is already in the sys_clk domain.
`timescale 1ns/1ns
module ocd_edge_detect
   import ocd_pkg::*;
(
   input  wire logic      sys_clk,
   input  wire logic      rstn,
   input  wire logic      restart,
   input  wire logic      sig_in,
   input  wire ocd_edge_t edge_sel,
   output logic           edge_pulse
);

   logic prev_q;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prev_q <= T16_BIT8_RESET;
      end else begin
         prev_q <= sig_in;
      end
   end

   // A restart suppresses the comparison so only a later transition counts.
   always_comb begin
      edge_pulse = 1'b0;
      if (!restart) begin
         case (edge_sel)
            OCD_EDGE_RISE: edge_pulse = sig_in & ~prev_q;
            OCD_EDGE_FALL: edge_pulse = ~sig_in & prev_q;
            OCD_EDGE_BOTH: edge_pulse = sig_in ^ prev_q;
            default:       edge_pulse = 1'b0;
         endcase
      end
   end

endmodule // ocd_edge_detect

// >>> rtl/ocd_option_decode.sv
// Option configuration decoder: loads fixed options and applies them to peripherals.
// Assumes option store answers a load request with a valid strobe; pins are asynchronous.
//
// Contract
// - Protection option blocks program read-back.
// - Wake-up option selects slow or fast delay.
// - Source zero routes port A0 or B5.
// - Source one routes port B0 or A4.
// - Comparator interrupt edge: both, rising, falling.
// - Gating option lets comparator gate PWM outputs.
// - Timer source 0010 uses fast oscillator, 16/32.
// - Scale bit 7 gives 6 or 7-bit PWM.
// - Enable and request registers need no reset.
// - Watchdog stops while slow oscillator disabled.
// - Rising bit 8 interrupts at 0x100, 0x300.
// - After restart, next matching bit 8 edge.
// - Falling bit 8 interrupts at 0x200, 0x400.
// - Crystal range bits 6:5: 01, 10, 11.
// - Crystal control bit 7 enables crystal.
// - Clock mode bit 0 makes A5 reset input.
// - Only digital-enabled input pins join wake-up.
`timescale 1ns/1ns
module ocd_option_decode
   import ocd_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   // Option store.
   output logic                  opt_load_req,
   input  wire logic             opt_valid,
   input  wire logic [OPT_W-1:0] opt_word,
   output logic                  opt_loaded,
   // Program read-back.
   input  wire logic             prog_read_req,
   input  wire logic [7:0]       prog_read_data,
   output logic [7:0]            prog_read_out,
   output logic                  prog_read_refused,
   // Wake-up.
   output logic [7:0]            wake_delay,
   output logic                  wake_fast,
   // Pins and external interrupts.
   input  wire logic [7:0]       port_a_pins,
   input  wire logic [7:0]       port_b_pins,
   input  wire logic [7:0]       port_a_dir_out,
   input  wire logic [7:0]       porta_digital_input_enable,
   input  wire logic [7:0]       portb_digital_input_enable,
   output logic [1:0]            ext_irq_src,
   output logic [15:0]           wake_pin_mask,
   output logic                  wake_pin_event,
   // Comparator and PWM.
   input  wire logic             comparator_out,
   output logic                  comparator_irq,
   input  wire logic [2:0]       pwm_raw,
   output logic [2:0]            pwm_out,
   // Timers 2 and 3.
   input  wire logic [7:0]       timer2_control,
   input  wire logic [7:0]       timer3_control,
   input  wire logic [7:0]       timer2_scale,
   input  wire logic [7:0]       timer3_scale,
   output logic [1:0]            timer_fast_clk_sel,
   output logic [1:0]            timer_clk_double,
   output logic [1:0]            pwm_res_reduced,
   output logic [1:0]            pwm_res_7bit,
   // Clocks and watchdog.
   input  wire logic [7:0]       clock_mode_reg,
   input  wire logic             internal_slow_osc_en,
   input  wire logic             watchdog_en,
   output logic                  watchdog_run,
   input  wire logic [7:0]       crystal_osc_control,
   output logic                  external_crystal_osc_en,
   output ocd_xtal_t             crystal_range,
   output logic                  external_reset_req,
   // Sixteen-bit timer bit-8 interrupt.
   input  wire logic [15:0]      sixteen_bit_timer,
   input  wire logic             t16_restart,
   input  wire logic             t16_edge_fall,
   output logic                  t16_irq
);

   logic [OPT_W-1:0] opt_q;
   ocd_ld_state_t    ld_state_q;
   logic [7:0]       pa_s1_q;
   logic [7:0]       pa_s2_q;
   logic [7:0]       pb_s1_q;
   logic [7:0]       pb_s2_q;
   logic [15:0]      wake_prev_q;
   logic             cmp_s1_q;
   logic             cmp_s2_q;
   logic             cmp_irq_raw;
   logic             t16_bit8_irq;
   logic             t16_restart_q;
   ocd_edge_t        cmp_edge;
   ocd_edge_t        t16_edge;
   logic [15:0]      wake_now;

   function automatic logic tm_src_fast(input logic [7:0] ctl);
      tm_src_fast = (ctl[TMCTL_SRC_MSB:TMCTL_SRC_LSB] == TMCTL_SRC_FAST);
   endfunction

   // Option store load sequence; the word is latched once and never rewritten.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ld_state_q <= OCD_LD_IDLE;
      end else begin
         case (ld_state_q)
            OCD_LD_IDLE: ld_state_q <= OCD_LD_REQ;
            OCD_LD_REQ:  if (opt_valid) ld_state_q <= OCD_LD_DONE;
            OCD_LD_DONE: ld_state_q <= OCD_LD_DONE;
            default:     ld_state_q <= OCD_LD_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         opt_q <= OPT_RESET;
      end else if (ld_state_q == OCD_LD_REQ && opt_valid) begin
         opt_q <= opt_word;
      end
   end

   assign opt_load_req = (ld_state_q == OCD_LD_REQ);
   assign opt_loaded   = (ld_state_q == OCD_LD_DONE);

   // Pin synchronisers.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pa_s1_q  <= 8'h00;
         pa_s2_q  <= 8'h00;
         pb_s1_q  <= 8'h00;
         pb_s2_q  <= 8'h00;
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
      end else begin
         pa_s1_q  <= port_a_pins;
         pa_s2_q  <= pa_s1_q;
         pb_s1_q  <= port_b_pins;
         pb_s2_q  <= pb_s1_q;
         cmp_s1_q <= comparator_out;
         cmp_s2_q <= cmp_s1_q;
      end
   end

   // Program read-back is refused while protected or before options are known.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prog_read_out     <= 8'h00;
         prog_read_refused <= 1'b0;
      end else begin
         prog_read_refused <= prog_read_req & (opt_q[OPT_SECURE_BIT] | ~opt_loaded);
         if (prog_read_req && opt_loaded && !opt_q[OPT_SECURE_BIT]) begin
            prog_read_out <= prog_read_data;
         end else begin
            prog_read_out <= 8'h00;
         end
      end
   end

   assign wake_fast  = opt_q[OPT_FASTWAKE_BIT];
   assign wake_delay = wake_fast ? WAKE_FAST_CNT : WAKE_SLOW_CNT;

   // External interrupt routing, registered as data.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ext_irq_src <= 2'h0;
      end else begin
         ext_irq_src[0] <= opt_q[OPT_IRQ0_BIT] ? pb_s2_q[5] : pa_s2_q[0];
         ext_irq_src[1] <= opt_q[OPT_IRQ1_BIT] ? pa_s2_q[4] : pb_s2_q[0];
      end
   end

   // Interrupt enable and request storage lives with the core and is not reset here.

   // Wake-up pins: only digital-enabled inputs contribute; cleared bits are analog.
   assign wake_pin_mask = {portb_digital_input_enable, porta_digital_input_enable};
   assign wake_now      = {pb_s2_q, pa_s2_q} & wake_pin_mask;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wake_prev_q    <= 16'h0000;
         wake_pin_event <= 1'b0;
      end else begin
         wake_prev_q    <= wake_now;
         wake_pin_event <= |(wake_now ^ wake_prev_q);
      end
   end

   // Comparator interrupt edge.
   always_comb begin
      case (opt_q[OPT_CMPEDGE_MSB:OPT_CMPEDGE_LSB])
         2'h1:    cmp_edge = OCD_EDGE_RISE;
         2'h2:    cmp_edge = OCD_EDGE_FALL;
         default: cmp_edge = OCD_EDGE_BOTH;
      endcase
   end

   ocd_edge_detect u_cmp_edge (
      .sys_clk    (sys_clk),
      .rstn       (rstn),
      .restart    (1'b0),
      .sig_in     (cmp_s2_q),
      .edge_sel   (cmp_edge),
      .edge_pulse (cmp_irq_raw)
   );

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         comparator_irq <= 1'b0;
      end else begin
         comparator_irq <= cmp_irq_raw;
      end
   end

   // PWM gating by comparator output.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pwm_out <= 3'h0;
      end else if (opt_q[OPT_PWMGATE_BIT]) begin
         pwm_out <= pwm_raw & {3{cmp_s2_q}};
      end else begin
         pwm_out <= pwm_raw;
      end
   end

   // Timer clock source and PWM resolution per timer.
   always_comb begin
      timer_fast_clk_sel[0] = tm_src_fast(timer2_control);
      timer_fast_clk_sel[1] = tm_src_fast(timer3_control);
      timer_clk_double      = timer_fast_clk_sel & {2{opt_q[OPT_TMCLK_BIT]}};
      pwm_res_reduced[0]    = timer2_scale[TMSCALE_PWM_BIT];
      pwm_res_reduced[1]    = timer3_scale[TMSCALE_PWM_BIT];
      pwm_res_7bit          = pwm_res_reduced & {2{opt_q[OPT_PWMRES_BIT]}};
   end

   // Watchdog needs the slow oscillator.
   assign watchdog_run = watchdog_en & internal_slow_osc_en;

   // Crystal oscillator control decode.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         external_crystal_osc_en <= 1'b0;
         crystal_range           <= OCD_XTAL_OFF;
      end else begin
         external_crystal_osc_en <= crystal_osc_control[XTAL_EN_BIT];
         case (crystal_osc_control[XTAL_RANGE_MSB:XTAL_RANGE_LSB])
            2'h1:    crystal_range <= OCD_XTAL_LOW;
            2'h2:    crystal_range <= OCD_XTAL_MID;
            2'h3:    crystal_range <= OCD_XTAL_HIGH;
            default: crystal_range <= OCD_XTAL_OFF;
         endcase
      end
   end

   // External reset from port A bit 5, active low, only when it is an input.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         external_reset_req <= 1'b0;
      end else begin
         external_reset_req <= clock_mode_reg[CLOCK_MODE_REG_RST_BIT] & ~port_a_dir_out[PIN_A_BIT5]
                               & ~pa_s2_q[PIN_A_BIT5];
      end
   end

   // Sixteen-bit timer bit-8 interrupt; a restart, registered once, masks any edge in the following cycle.
   assign t16_edge = t16_edge_fall ? OCD_EDGE_FALL : OCD_EDGE_RISE;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         t16_restart_q <= 1'b0;
      end else begin
         t16_restart_q <= t16_restart;
      end
   end

   ocd_edge_detect u_t16_edge (
      .sys_clk    (sys_clk),
      .rstn       (rstn),
      .restart    (t16_restart_q),
      .sig_in     (sixteen_bit_timer[8]),
      .edge_sel   (t16_edge),
      .edge_pulse (t16_bit8_irq)
   );

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         t16_irq <= 1'b0;
      end else begin
         t16_irq <= t16_bit8_irq;
      end
   end

   // Checks.
   sequence seq_rise8;
      !sixteen_bit_timer[8] ##1 sixteen_bit_timer[8];
   endsequence

   sequence seq_fall8;
      sixteen_bit_timer[8] ##1 !sixteen_bit_timer[8];
   endsequence

   AST_READ_REFUSED: assert property (@(posedge sys_clk) disable iff (!rstn)
      prog_read_req && opt_q[OPT_SECURE_BIT] |=> prog_read_refused && prog_read_out == 8'h00)
      else $error("Protected read was not refused.");

   AST_WAKE_SEL: assert property (@(posedge sys_clk) disable iff (!rstn)
      wake_delay == (opt_q[OPT_FASTWAKE_BIT] ? WAKE_FAST_CNT : WAKE_SLOW_CNT))
      else $error("Wake delay does not follow option.");

   AST_IRQ0_ROUTE: assert property (@(posedge sys_clk) disable iff (!rstn)
      opt_loaded |=> ext_irq_src[0] == ($past(opt_q[OPT_IRQ0_BIT]) ? $past(pb_s2_q[5])
                                                                  : $past(pa_s2_q[0])))
      else $error("Interrupt source zero misrouted.");

   AST_IRQ1_ROUTE: assert property (@(posedge sys_clk) disable iff (!rstn)
      opt_loaded |=> ext_irq_src[1] == ($past(opt_q[OPT_IRQ1_BIT]) ? $past(pa_s2_q[4])
                                                                  : $past(pb_s2_q[0])))
      else $error("Interrupt source one misrouted.");

   AST_CMP_RISE: assert property (@(posedge sys_clk) disable iff (!rstn)
      cmp_edge == OCD_EDGE_RISE && $fell(cmp_s2_q) |=> !comparator_irq)
      else $error("Comparator fired on wrong edge.");

   AST_PWM_GATE: assert property (@(posedge sys_clk) disable iff (!rstn)
      opt_q[OPT_PWMGATE_BIT] && !cmp_s2_q |=> pwm_out == 3'h0)
      else $error("PWM not gated by comparator.");

   AST_TM_CLK: assert property (@(posedge sys_clk) disable iff (!rstn)
      timer_clk_double[0] |-> timer2_control[7:4] == TMCTL_SRC_FAST && opt_q[OPT_TMCLK_BIT])
      else $error("Timer clock doubling without cause.");

   AST_WDT_STOP: assert property (@(posedge sys_clk) disable iff (!rstn)
      !internal_slow_osc_en |-> !watchdog_run)
      else $error("Watchdog runs without slow oscillator.");

   // Edge setting and restart mask are judged in the cycle that shows the new bit 8.
   AST_T16_RISE: assert property (@(posedge sys_clk) disable iff (!rstn)
      seq_rise8 ##0 (!t16_edge_fall && !t16_restart_q) |=> t16_irq)
      else $error("Missed rising bit 8 interrupt.");

   AST_T16_FALL: assert property (@(posedge sys_clk) disable iff (!rstn)
      seq_fall8 ##0 (t16_edge_fall && !t16_restart_q) |=> t16_irq)
      else $error("Missed falling bit 8 interrupt.");

   AST_XTAL_EN: assert property (@(posedge sys_clk) disable iff (!rstn)
      crystal_osc_control[XTAL_EN_BIT] |=> external_crystal_osc_en)
      else $error("Crystal enable not applied.");

   AST_OPT_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
      opt_loaded |=> $stable(opt_q))
      else $error("Options changed after load.");

endmodule // ocd_option_decode

// >>> testbench/ocd_option_decode_bench.sv
// Self-checking bench for the option configuration decoder.
// Assumes the decoder ports as declared; the bench plays the option store, pins and timers.
`timescale 1ns/1ns
module ocd_option_decode_bench
   import ocd_pkg::*;
;
   logic             sys_clk, rstn, opt_valid, prog_read_req, comparator_out;
   logic             internal_slow_osc_en, watchdog_en, t16_restart, t16_edge_fall;
   logic [OPT_W-1:0] opt_word;
   logic [7:0]       prog_read_data, port_a_pins, port_b_pins, port_a_dir_out;
   logic [7:0]       porta_digital_input_enable, portb_digital_input_enable;
   logic [7:0]       timer2_control, timer3_control, timer2_scale, timer3_scale;
   logic [7:0]       clock_mode_reg, crystal_osc_control, prog_read_out, wake_delay;
   logic [2:0]       pwm_raw, pwm_out;
   logic [15:0]      sixteen_bit_timer, wake_pin_mask;
   logic             opt_load_req, opt_loaded, prog_read_refused, wake_fast, wake_pin_event;
   logic             comparator_irq, watchdog_run, external_crystal_osc_en;
   logic             external_reset_req, t16_irq;
   logic [1:0]       ext_irq_src, timer_fast_clk_sel, timer_clk_double;
   logic [1:0]       pwm_res_reduced, pwm_res_7bit;
   ocd_xtal_t        crystal_range;
   int               n_fail, check_count, cmp_n, wake_n;
   logic [15:0]      t16_log[$];

   ocd_option_decode dut (
      .sys_clk, .rstn, .opt_load_req, .opt_valid, .opt_word, .opt_loaded,
      .prog_read_req, .prog_read_data, .prog_read_out, .prog_read_refused,
      .wake_delay, .wake_fast, .port_a_pins, .port_b_pins, .port_a_dir_out,
      .porta_digital_input_enable, .portb_digital_input_enable, .ext_irq_src,
      .wake_pin_mask, .wake_pin_event, .comparator_out, .comparator_irq, .pwm_raw,
      .pwm_out, .timer2_control, .timer3_control, .timer2_scale, .timer3_scale,
      .timer_fast_clk_sel, .timer_clk_double, .pwm_res_reduced, .pwm_res_7bit,
      .clock_mode_reg, .internal_slow_osc_en, .watchdog_en, .watchdog_run,
      .crystal_osc_control, .external_crystal_osc_en, .crystal_range,
      .external_reset_req, .sixteen_bit_timer, .t16_restart, .t16_edge_fall, .t16_irq
   );

   initial sys_clk = 1'b0;
   always #50 sys_clk = ~sys_clk;

   // Pulse outputs are counted just after the edge that launches them.
   // A pulse thus counts once, and the logged timer value is the one that raised it.
   always @(posedge sys_clk) begin
      #1;
      if (comparator_irq === 1'b1) cmp_n++;
      if (wake_pin_event === 1'b1) wake_n++;
      if (t16_irq === 1'b1) t16_log.push_back(sixteen_bit_timer);
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Resets, reads once before the load, then answers the load request with the word.
   task automatic power_up(input logic [OPT_W-1:0] word);
      int i;
      rstn = 1'b0;
      opt_valid = 1'b0;
      opt_word = word;
      tick(3);
      rstn = 1'b1;
      prog_read_req = 1'b1;
      prog_read_data = 8'h3c;
      tick(1);
      chk(prog_read_refused, 1, "read before load");
      prog_read_req = 1'b0;
      for (i = 0; i < 10 && opt_load_req !== 1'b1; i++) tick(1);
      opt_valid = 1'b1;
      for (i = 0; i < 10 && opt_loaded !== 1'b1; i++) tick(1);
      chk(opt_loaded, 1, "options loaded");
      opt_valid = 1'b0;
      chk(opt_load_req, 0, "load request dropped");
   endtask

   // Leaves the request high so that calls may follow back to back.
   task automatic rd(input logic [7:0] d, input logic refused);
      prog_read_req = 1'b1;
      prog_read_data = d;
      tick(1);
      chk(prog_read_refused, refused, "read refused flag");
      chk(prog_read_out, refused ? 8'h00 : d, "read data");
   endtask

   task automatic route(input logic [7:0] a, input logic [7:0] b, input logic [1:0] exp);
      port_a_pins = a;
      port_b_pins = b;
      tick(5);
      chk(ext_irq_src, exp, "interrupt source routing");
   endtask

   task automatic cmp_pwm(input logic gate, input int edges);
      cmp_n = 0;
      pwm_raw = 3'b101;
      comparator_out = 1'b1;
      tick(6);
      chk(pwm_out, 3'b101, "pwm with comparator high");
      comparator_out = 1'b0;
      tick(6);
      chk(pwm_out, gate ? 3'b000 : 3'b101, "pwm with comparator low");
      chk(16'(cmp_n), 16'(edges), "comparator interrupt count");
   endtask

   task automatic tmr(input logic [31:0] regs, input logic [7:0] exp);
      {timer2_control, timer3_control, timer2_scale, timer3_scale} = regs;
      tick(1);
      chk(timer_fast_clk_sel, exp[7:6], "timer fast clock select");
      chk(timer_clk_double, exp[5:4], "timer clock doubling");
      chk(pwm_res_reduced, exp[3:2], "pwm reduced resolution");
      chk(pwm_res_7bit, exp[1:0], "pwm 7-bit resolution");
   endtask

   task automatic t16_run(input int from, input int upto);
      for (int v = from; v <= upto; v++) begin
         sixteen_bit_timer = 16'(v);
         tick(1);
      end
   endtask

   task automatic t16_expect(input logic [15:0] e0, input logic [15:0] e1, input int n);
      tick(2);
      chk(16'(t16_log.size()), 16'(n), "timer interrupt count");
      chk(t16_log[0], e0, "first timer interrupt");
      if (n > 1) chk(t16_log[1], e1, "second timer interrupt");
      t16_log.delete();
   endtask

   task automatic rpin(input logic [7:0] cm, input logic [7:0] dir, input logic [7:0] a,
                       input logic exp);
      clock_mode_reg = cm;
      port_a_dir_out = dir;
      port_a_pins = a;
      tick(5);
      chk(external_reset_req, exp, "external reset request");
   endtask

   initial begin
      #(5000 * 100);
      n_fail++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test();
   end

   initial begin
      {rstn, opt_valid, prog_read_req, comparator_out, t16_restart, t16_edge_fall} = '0;
      {internal_slow_osc_en, watchdog_en} = '0;
      {opt_word, prog_read_data, port_a_pins, port_b_pins, port_a_dir_out} = '0;
      {porta_digital_input_enable, portb_digital_input_enable} = 16'hffff;
      {timer2_control, timer3_control, timer2_scale, timer3_scale} = '0;
      {clock_mode_reg, crystal_osc_control, pwm_raw, sixteen_bit_timer} = '0;
      n_fail = 0;
      check_count = 0;
      cmp_n = 0;
      wake_n = 0;
      // Protected, fast wake, alternate routing, rising edge, gated, doubled, 7-bit.
      power_up(10'h1df);
      rd(8'ha5, 1'b1);
      chk(wake_fast, 1, "fast wake");
      chk(wake_delay, WAKE_FAST_CNT, "fast wake delay");
      // The bench owns no interrupt enable or request registers, so it never enables early.
      route(8'h00, 8'h20, 2'b01);
      route(8'h10, 8'h00, 2'b10);
      route(8'h01, 8'h01, 2'b00);
      cmp_pwm(1'b1, 1);
      tmr(32'h2030_0080, 8'b01_01_10_10);
      t16_run(0, 16'h320);
      t16_expect(16'h100, 16'h300, 2);
      // Park the timer at zero so the next falling-edge run starts without a stale edge.
      sixteen_bit_timer = 16'h0000;
      opt_word = 10'h000;
      opt_valid = 1'b1;
      tick(3);
      opt_valid = 1'b0;
      chk(wake_fast, 1, "options fixed after load");
      $display("Test protected options done");
      // Open, slow wake, default routing, falling edge, ungated, 16 MHz, 6-bit.
      t16_edge_fall = 1'b1;
      power_up(10'h020);
      rd(8'h5a, 1'b0);
      rd(8'hc3, 1'b0);
      prog_read_req = 1'b0;
      chk(wake_delay, WAKE_SLOW_CNT, "slow wake delay");
      route(8'h01, 8'h00, 2'b01);
      route(8'h00, 8'h01, 2'b10);
      route(8'h10, 8'h20, 2'b00);
      cmp_pwm(1'b0, 1);
      tmr(32'h2020_8080, 8'b11_00_11_00);
      t16_run(0, 16'h620);
      t16_expect(16'h200, 16'h400, 3);
      t16_run(16'h700, 16'h780);
      t16_restart = 1'b1;
      tick(1);
      t16_restart = 1'b0;
      t16_run(0, 16'h220);
      t16_expect(16'h200, 16'h0000, 1);
      $display("Test open options done");
      // Both comparator edges, then option-free controls.
      t16_edge_fall = 1'b0;
      power_up(10'h000);
      cmp_pwm(1'b0, 2);
      for (int i = 0; i < 4; i++) begin
         {internal_slow_osc_en, watchdog_en} = 2'(i);
         tick(1);
         chk(watchdog_run, i == 3, "watchdog run");
      end
      for (int i = 0; i < 8; i++) begin
         // The system clock is never moved onto the crystal, proven or not.
         crystal_osc_control = 8'(i << 5);
         tick(2);
         chk(external_crystal_osc_en, i[2], "crystal enable");
         chk(crystal_range, 16'(i & 3), "crystal range");
      end
      rpin(8'h00, 8'h00, 8'h00, 1'b0);
      rpin(8'h01, 8'h00, 8'h00, 1'b1);
      rpin(8'h01, 8'h20, 8'h00, 1'b0);
      rpin(8'h01, 8'h00, 8'h20, 1'b0);
      // Clock mode writes only touch the reset-pin bit, never the clock source.
      clock_mode_reg = 8'h00;
      porta_digital_input_enable = 8'h01;
      portb_digital_input_enable = 8'h80;
      tick(6);
      chk(wake_pin_mask, 16'h8001, "wake pin mask");
      wake_n = 0;
      port_a_pins = 8'h26;
      port_b_pins = 8'h7f;
      tick(6);
      chk(16'(wake_n), 16'h0000, "disabled pins silent");
      port_a_pins = 8'h27;
      tick(6);
      port_b_pins = 8'hff;
      tick(6);
      chk(16'(wake_n), 16'h0002, "enabled pins wake");
      $display("Test controls done");
      end_of_test();
   end
endmodule // ocd_option_decode_bench
